//--- design/tcmio_pkg.sv
// Package for the timer channel mode and channel 2 register B I/O block.
// Assumes an APB slave with 32-bit data and one register per word.
`default_nettype none
package tcmio_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_IOCTL = 8'h04;
   localparam logic [7:0] OFS_GRB = 8'h08;
   localparam logic [7:0] OFS_GRD = 8'h0c;
   localparam logic [7:0] OFS_GRA = 8'h10;
   localparam logic [7:0] OFS_GRC = 8'h14;
   localparam logic [7:0] OFS_CNT = 8'h18;
   localparam logic [7:0] OFS_STAT = 8'h1c;
   localparam logic [7:0] OFS_IEN = 8'h20;
   localparam logic [7:0] OFS_ICLR = 8'h24;
   localparam logic [7:0] OFS_STATUS = 8'h28;
   // Mode register layout and reset
   localparam int MODE_BFB = 5;
   localparam int MODE_BFA = 4;
   localparam int MODE_MD3 = 3;
   localparam logic [7:0] MODE_RESET = 8'hc0;
   localparam logic [7:0] MODE_WMASK = 8'h37;
   // I/O control field layout
   localparam int IO_CAPSEL = 3;
   localparam int IO_INIT = 2;
   localparam logic [3:0] IOCTL_RESET = 4'h0;
   // Event status bits
   localparam int EV_MATCH = 0;
   localparam int EV_CAPTURE = 1;
   localparam int EV_NUM = 2;
   // Operating modes
   typedef enum logic [3:0] {
      TCMIO_NORMAL = 4'b0000,
      TCMIO_RSVD = 4'b0001,
      TCMIO_PWM1 = 4'b0010,
      TCMIO_PWM2 = 4'b0011,
      TCMIO_PH1 = 4'b0100,
      TCMIO_PH2 = 4'b0101,
      TCMIO_PH3 = 4'b0110,
      TCMIO_PH4 = 4'b0111
   } tcmio_mode_t;
   // Compare action on low two I/O bits
   typedef enum logic [1:0] {
      TCMIO_OUT_OFF = 2'b00,
      TCMIO_OUT_LOW = 2'b01,
      TCMIO_OUT_HIGH = 2'b10,
      TCMIO_OUT_TOG = 2'b11
   } tcmio_act_t;
   // Pin drive bundle
   typedef struct packed {
      logic out;
      logic oe;
   } tcmio_pin_t;
endpackage : tcmio_pkg
`default_nettype wire

//--- design/tcmio_sync.sv
// Three-stage pin synchroniser with agreement of the last two stages.
// Assumes an asynchronous input; output changes once stages 2 and 3 agree.
`default_nettype none
module tcmio_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Pin in, clean level out
   input wire logic pinIn,
   output logic level
);
   import tcmio_pkg::*;
   // Three stages
   logic [2:0] stage_q;
   // Shift chain
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stage_q <= 3'h0;
      end else begin
         stage_q <= {stage_q[1:0], pinIn};
      end
   end
   // Accept a change only when stages agree
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         level <= 1'b0;
      end else if (stage_q[1] == stage_q[2]) begin
         level <= stage_q[2];
      end
   end
endmodule : tcmio_sync
`default_nettype wire

//--- design/tcmio_edge.sv
// Edge selector for capture: rising, falling or both.
// Assumes a clean synchronous level input.
`default_nettype none
module tcmio_edge (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Level and selection
   input wire logic level,
   input wire logic [1:0] edgeSel,
   // Selected edge pulse
   output logic hit
);
   import tcmio_pkg::*;
   // Previous level
   logic prev_q;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= level;
      end
   end
   // Edge decode
   always_comb begin
      if (edgeSel[1]) begin
         // R06 both edges
         hit = level ^ prev_q;
      end else if (edgeSel[0]) begin
         // R05 falling edge
         hit = prev_q & ~level;
      end else begin
         // R04 rising edge
         hit = level & ~prev_q;
      end
   end
endmodule : tcmio_edge
`default_nettype wire

//--- design/tcmio_top.sv
// Timer channel mode and register B compare/capture control, APB slave.
// Assumes a free-running 16-bit counter here and an external pin buffer.
`default_nettype none
// How it works
// R01: Compare 01 drives pin low on match
// R02: Compare 10 drives pin high on match
// R03: Compare 11 toggles pin on match
// R04: Capture 00 latches counter on rising edge
// R05: Capture 01 latches counter on falling edge
// R06: Capture 1x latches on both edges
// R07: Buffer B bit makes D buffer B
// R08: Mode field selects operation; A pairs C
module tcmio_top #(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Compare/capture pin
   input wire logic ch2BPinIn,
   output tcmio_pkg::tcmio_pin_t ch2BPin,
   // Interrupt and mode
   output logic irq,
   output tcmio_pkg::tcmio_mode_t opMode
);
   import tcmio_pkg::*;

   // Elaboration check: the counter must fit one 32-bit data word
   if (CNT_W < 1 || CNT_W > 32) begin : gBadWidth
      $error("CNT_W out of range");
   end

   // Mode and I/O control registers
   logic [7:0] mode_q; // Buffer bits and mode field
   logic [3:0] ioCtl_q; // Register B compare/capture control
   // General registers and counter
   logic [CNT_W-1:0] grA_q; // Compare register A
   logic [CNT_W-1:0] grB_q; // Compare or capture register B
   logic [CNT_W-1:0] grC_q; // Buffer of A
   logic [CNT_W-1:0] grD_q; // Buffer of B
   logic [CNT_W-1:0] count_q; // Free-running count
   // Event status and enable
   logic [EV_NUM-1:0] stat_q; // Sticky event bits
   logic [EV_NUM-1:0] ien_q; // Interrupt enables
   // Internal nets
   logic pinLvl_q; // Compare output level
   logic pinLevel; // Synchronised pin level
   logic capHit; // Selected capture edge seen
   logic matchB; // Counter equals B in compare mode
   logic matchA; // Counter equals A
   logic wrEn; // Write commits on this edge
   logic rdEn; // Read access phase
   logic addrOk; // Address maps to a register
   logic [CNT_W-1:0] wrVal; // Write data cut to counter width

   // Bus strobes: a write lands only on the edge that carries pready,
   // so a counter load or a status clear is applied exactly once
   assign wrEn = psel & penable & pwrite & pready;
   assign rdEn = psel & penable & ~pwrite;
   assign wrVal = pwdata[CNT_W-1:0];
   // Known addresses
   always_comb begin
      unique case (paddr)
         OFS_MODE, OFS_IOCTL, OFS_GRB, OFS_GRD, OFS_GRA, OFS_GRC,
         OFS_CNT, OFS_STAT, OFS_IEN, OFS_ICLR, OFS_STATUS: addrOk = 1'b1;
         default: addrOk = 1'b0;
      endcase
   end

   // Pin synchroniser: three flops against metastability
   // A pin edge reaches the edge detector three to four clocks late
   tcmio_sync uSync (
      .clk(clk),
      .reset_n(reset_n),
      .pinIn(ch2BPinIn),
      .level(pinLevel)
   );

   // Capture edge selection
   // Bits 1:0 of the control pick rising, falling or both edges
   tcmio_edge uEdge (
      .clk(clk),
      .reset_n(reset_n),
      .level(pinLevel),
      .edgeSel(ioCtl_q[1:0]),
      .hit(capHit)
   );

   // Compare matches
   // B compares only while the control selects compare mode
   assign matchB = ~ioCtl_q[IO_CAPSEL] && (count_q == grB_q);
   assign matchA = (count_q == grA_q);

   // Mode register, only writable bits change
   // Bits 7:6 always read 1 and bit 3 always reads 0
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_q <= MODE_RESET;
      end else if (wrEn && paddr == OFS_MODE) begin
         // R08 reserved bit 3 kept 0, bits 7:6 kept 1
         mode_q <= (MODE_RESET & ~MODE_WMASK) | (pwdata[7:0] & MODE_WMASK);
      end
   end

   // Mode output
   // Registered copy of the mode field for the counter core
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         opMode <= TCMIO_NORMAL;
      end else begin
         // R08 mode field decode
         opMode <= tcmio_mode_t'({1'b0, mode_q[2:0]});
      end
   end

   // I/O control register
   // Bit 3 picks capture, bit 2 the initial compare level
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ioCtl_q <= IOCTL_RESET;
      end else if (wrEn && paddr == OFS_IOCTL) begin
         // Software write
         ioCtl_q <= pwdata[3:0];
      end
   end

   // Free-running counter; wraps at full scale so compares recur
   // Software may load it to line up a compare or a capture window
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count_q <= '0;
      end else if (wrEn && paddr == OFS_CNT) begin
         // Software load
         count_q <= wrVal;
      end else begin
         // Count one per clock
         count_q <= count_q + 1'b1;
      end
   end

   // Register A with optional buffer C
   // A software write wins over a buffer transfer in the same cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         grA_q <= '1;
      end else if (wrEn && paddr == OFS_GRA) begin
         // Software write
         grA_q <= wrVal;
      end else if (mode_q[MODE_BFA] && matchA) begin
         // R08 C reloads A on match
         grA_q <= grC_q;
      end
   end

   // Register C, buffer of A
   // Holds the next A value while A is being compared
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         grC_q <= '1;
      end else if (wrEn && paddr == OFS_GRC) begin
         // Software write
         grC_q <= wrVal;
      end
   end

   // Register B: capture, buffered compare, or plain
   // A capture beats a software write so that no pin edge is lost
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         grB_q <= '1;
      end else if (ioCtl_q[IO_CAPSEL] && capHit) begin
         // R04 latch counter on selected edge
         grB_q <= count_q;
      end else if (wrEn && paddr == OFS_GRB) begin
         // Software write
         grB_q <= wrVal;
      end else if (mode_q[MODE_BFB] && matchB) begin
         // R07 D transfers into B
         grB_q <= grD_q;
      end
   end

   // Register D, buffer of B
   // Keeps the old B on capture, so two captures stay readable
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         grD_q <= '1;
      end else if (mode_q[MODE_BFB] && ioCtl_q[IO_CAPSEL] && capHit) begin
         // R07 old B moves to D on capture
         grD_q <= grB_q;
      end else if (wrEn && paddr == OFS_GRD) begin
         // Software write
         grD_q <= wrVal;
      end
   end

   // Pin level for compare output
   // Writing the control presets the level, so the pin starts from
   // a known state before the first match
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pinLvl_q <= 1'b0;
      end else if (wrEn && paddr == OFS_IOCTL) begin
         // Initial level on configuration
         pinLvl_q <= pwdata[IO_INIT];
      end else if (matchB) begin
         unique case (tcmio_act_t'(ioCtl_q[1:0]))
            // R01 low on match
            TCMIO_OUT_LOW: pinLvl_q <= 1'b0;
            // R02 high on match
            TCMIO_OUT_HIGH: pinLvl_q <= 1'b1;
            // R03 toggle on match
            TCMIO_OUT_TOG: pinLvl_q <= ~pinLvl_q;
            TCMIO_OUT_OFF: pinLvl_q <= pinLvl_q;
         endcase
      end
   end

   // Pin drive
   // Registered, so the pin cannot glitch while the control changes
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ch2BPin <= '0;
      end else begin
         // R01 disabled when low bits 00
         ch2BPin.oe <= ~ioCtl_q[IO_CAPSEL] &&
            (ioCtl_q[1:0] != TCMIO_OUT_OFF);
         ch2BPin.out <= pinLvl_q;
      end
   end

   // Sticky status, set beats clear
   // An event in the clear cycle survives, so none is ever lost
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stat_q <= '0;
      end else begin
         for (int i = 0; i < EV_NUM; i++) begin
            if ((i == EV_MATCH && matchB) ||
                (i == EV_CAPTURE && ioCtl_q[IO_CAPSEL] && capHit)) begin
               stat_q[i] <= 1'b1;
            end else if (wrEn && paddr == OFS_ICLR && pwdata[i]) begin
               stat_q[i] <= 1'b0;
            end
         end
      end
   end

   // Interrupt enable
   // Enables only mask the output; status keeps latching
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ien_q <= '0;
      end else if (wrEn && paddr == OFS_IEN) begin
         // Software write
         ien_q <= pwdata[EV_NUM-1:0];
      end
   end

   // Interrupt output
   // Level output, one clock behind the status bits
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(stat_q & ien_q);
      end
   end

   // APB answer: one wait cycle, data registered
   // Unmapped addresses answer with pslverr and zero data
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else if (psel && penable && !pready) begin
         // First access edge: answer on the next clock
         pready <= 1'b1;
         pslverr <= ~addrOk;
         prdata <= '0;
         // Read data only for reads; writes return zero
         if (rdEn) begin
            unique case (paddr)
               OFS_MODE: prdata[7:0] <= mode_q;
               OFS_IOCTL: prdata[3:0] <= ioCtl_q;
               OFS_GRA: prdata[CNT_W-1:0] <= grA_q;
               OFS_GRB: prdata[CNT_W-1:0] <= grB_q;
               OFS_GRC: prdata[CNT_W-1:0] <= grC_q;
               OFS_GRD: prdata[CNT_W-1:0] <= grD_q;
               OFS_CNT: prdata[CNT_W-1:0] <= count_q;
               OFS_STAT: prdata[EV_NUM-1:0] <= stat_q;
               OFS_IEN: prdata[EV_NUM-1:0] <= ien_q;
               OFS_STATUS: prdata[0] <= pinLevel;
               default: prdata <= '0;
            endcase
         end
      end else begin
         // Drop the answer after one cycle
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end
endmodule : tcmio_top
`default_nettype wire

//--- bench/tcmio_top_props.sv
// Port checker for the timer mode and compare/capture block.
// Assumes one clock domain and the package register offsets.
`default_nettype none
module tcmio_top_props (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pin and mode
   input wire tcmio_pkg::tcmio_pin_t ch2BPin,
   input wire tcmio_pkg::tcmio_mode_t opMode
);
   timeunit 1ns;
   timeprecision 1ps;
   import tcmio_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Register writes seen on the bus
   logic modeWr;
   logic ioWr;
   assign modeWr = psel && pwrite && paddr == OFS_MODE;
   assign ioWr = psel && pwrite && paddr == OFS_IOCTL;
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
      else $error("pready not after one wait state");
   a_ready_cause: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   a_err_ready: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error response malformed");
   a_mode_rsvd: assert property (opMode[3] == 1'b0)
      else $error("reserved mode bit set");
   a_mode_hold: assert property (!$stable(opMode) |-> $past(modeWr) ||
      $past(modeWr, 2)) else $error("mode changed without write");
   a_oe_hold: assert property (!$stable(ch2BPin.oe) |-> $past(ioWr) ||
      $past(ioWr, 2) || $past(ioWr, 3)) else $error("oe changed alone");
   a_ready_once: assert property (pready |=> !(psel && penable && pready))
      else $error("second answer to one request");
endmodule : tcmio_top_props
`default_nettype wire

//--- bench/tcmio_pin_far.sv
// Far-side circuit driving the capture pin.
// Assumes the bench calls drive from its main sequence.
`default_nettype none
module tcmio_pin_far (
   // Clock
   input wire logic clk,
   // Pin level toward the block
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial pin = 1'b0;
   // Change the pin just after an edge
   task automatic drive(input logic v);
      @(posedge clk);
      pin <= v;
   endtask : drive
endmodule : tcmio_pin_far
`default_nettype wire

//--- bench/tb.sv
// Self-checking bench for the timer mode and compare/capture block.
// Assumes the design package, the pin model and the port checker.
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
   $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import tcmio_pkg::*;
   logic clk, reset_n, psel, penable, pwrite, pready, pslverr, pinIn, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   tcmio_pin_t pinOut;
   tcmio_mode_t opMode;
   logic [15:0] rnd;
   logic [3:0] io;
   int n_fail, check_count, cyc;
   tcmio_top u_tcmio_top (.clk(clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ch2BPinIn(pinIn), .ch2BPin(pinOut), .irq(irq), .opMode(opMode));
   tcmio_pin_far u_far (.clk(clk), .pin(pinIn));
   always #5 clk = ~clk;
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   // Level after one compare match
   function automatic logic expOut(input logic [3:0] c);
      return c[1:0] == 2'b11 ? ~c[2] : c[1];
   endfunction : expOut
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : wrap_up
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         wrap_up();
      end
   end
   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic pause(input int n);
      repeat (n) @(posedge clk);
   endtask : pause
   initial begin
      {clk, reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
      rnd = 16'h3c17;
      pause(12);
      reset_n <= 1'b1;
      apb(0, OFS_MODE, 0);
      `CHK(q[7:0], MODE_RESET)
      apb(0, OFS_GRB, 0);
      `CHK(q[15:0], 16'hffff)
      for (int m = 0; m < 8; m++) begin
         rnd = lfsr(rnd);
         apb(1, OFS_MODE, {24'h0, rnd[7:6], 2'b00, rnd[3], m[2:0]});
         pause(3);
         `CHK(opMode, tcmio_mode_t'({1'b0, m[2:0]}))
         apb(0, OFS_MODE, 0);
         `CHK(q[7:0], {5'b11000, m[2:0]})
      end
      apb(1, OFS_MODE, 0);
      for (int k = 0; k < 8; k++) begin
         io = k[3:0];
         apb(1, OFS_IOCTL, {28'h0, io});
         pause(3);
         `CHK(pinOut.oe, io[1:0] != 2'b00)
         apb(1, OFS_CNT, 0);
         apb(1, OFS_GRB, 30);
         pause(60);
         if (io[1:0] != 2'b00) `CHK(pinOut.out, expOut(io))
      end
      apb(1, OFS_ICLR, 3);
      apb(1, OFS_IEN, 1);
      pause(3);
      `CHK(irq, 1'b0)
      apb(1, OFS_MODE, 32'h30);
      rnd = lfsr(rnd) | 16'h8000;
      apb(1, OFS_GRD, rnd);
      apb(1, OFS_GRC, rnd ^ 16'h00ff);
      apb(1, OFS_CNT, 0);
      apb(1, OFS_GRB, 20);
      apb(1, OFS_GRA, 20);
      pause(40);
      apb(0, OFS_GRB, 0);
      `CHK(q[15:0], rnd)
      apb(0, OFS_GRA, 0);
      `CHK(q[15:0], rnd ^ 16'h00ff)
      `CHK(irq, 1'b1)
      apb(1, OFS_IEN, 0);
      pause(3);
      `CHK(irq, 1'b0)
      apb(1, OFS_IEN, 1);
      apb(1, OFS_ICLR, 1);
      pause(3);
      `CHK(irq, 1'b0)
      apb(1, OFS_MODE, 0);
      apb(1, OFS_GRD, 16'h1234);
      apb(1, OFS_CNT, 0);
      apb(1, OFS_GRB, 20);
      pause(40);
      apb(0, OFS_GRB, 0);
      `CHK(q[15:0], 16'h0014)
      for (int s = 0; s < 4; s++) begin
         rnd = lfsr(rnd);
         apb(1, OFS_IOCTL, {28'h0, 1'b1, rnd[0], s[1:0]});
         pause(10);
         `CHK(pinOut.oe, 1'b0)
         apb(1, OFS_ICLR, 3);
         u_far.drive(1'b1);
         pause(10);
         apb(0, OFS_STAT, 0);
         `CHK(q[1], s != 1)
         apb(1, OFS_ICLR, 3);
         u_far.drive(1'b0);
         pause(10);
         apb(0, OFS_STAT, 0);
         `CHK(q[1], s != 0)
      end
      reset_n <= 1'b0;
      pause(2);
      reset_n <= 1'b1;
      apb(0, OFS_MODE, 0);
      `CHK(q[7:0], MODE_RESET)
      `CHK(pinOut.oe, 1'b0)
      apb(0, 8'h40, 0);
      `CHK(q, 32'h0)
      wrap_up();
   end
endmodule : tb
bind tcmio_top tcmio_top_props u_props (.clk(clk), .reset_n(reset_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .ch2BPin(ch2BPin), .opMode(opMode));
`default_nettype wire
